// [uart_break_detect.sv]
// counts bit times while the selected receive line is low
// assumes a one-cycle bit tick from the baud generator
`timescale 1ns/1ps
module uart_break_detect #(
  parameter logic [3:0] MAX_BITS = 4'hc
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // line and bit timing
  input wire logic line_i,
  input wire logic bit_tick_i,
  // one pulse per low period longer than the longest frame
  output logic break_o
);
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic brk_q;
  logic brk_d;

  // =========================================================
  // saturating count; pulse only once per low stretch
  always_comb begin
    cnt_d = cnt_q;
    brk_d = 1'b0;
    if (line_i) begin
      cnt_d = 5'h00;
    end else if (bit_tick_i && cnt_q != 5'h1f) begin
      cnt_d = cnt_q + 5'h01;
      brk_d = (cnt_q == {1'b0, MAX_BITS}); // longer than the frame
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_q <= 5'h00;
      brk_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      brk_q <= brk_d;
    end
  end

  assign break_o = brk_q;
endmodule : uart_break_detect

// [uart_far_side.sv]
// far-side model: the shift register that drains the holding register
// assumes one clock shared with the block; stall_i holds off every take
`timescale 1ns/1ps
module uart_far_side #(
  parameter int SEND_CYCLES = 6
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // holding register side
  input wire logic thr_valid_i,
  input wire logic stall_i,
  output logic shift_take_o,
  output logic shift_busy_o,
  output logic shift_out_o
);
  logic [3:0] cnt_q, cnt_d;
  logic take_d;
  // =========================================================
  // take a byte only while valid and idle; the guard blocks a double take
  always_comb begin
    take_d = thr_valid_i && !stall_i && cnt_q == 4'h0 && !shift_take_o;
    cnt_d = cnt_q;
    if (take_d) begin
      cnt_d = SEND_CYCLES[3:0];
    end else if (cnt_q != 4'h0) begin
      cnt_d = cnt_q - 4'h1;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_q <= 4'h0;
      shift_take_o <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      shift_take_o <= take_d;
    end
  end
  // line toggles while sending so a stuck copy shows; idle line is high
  assign shift_busy_o = cnt_q != 4'h0;
  assign shift_out_o = shift_busy_o ? cnt_q[0] : 1'b1;
endmodule : uart_far_side

// [uart_lsr_pkg.sv]
// constants for the uart line status, input mux and interrupt enable block
// assumes a byte-wide register port with full 32-bit byte addresses
package uart_lsr_pkg;
  // ==========================================================
  // register byte addresses
  localparam logic [31:0] ADDR_DATA = 32'hffff0700; // tx holding write, rx buffer read
  localparam logic [31:0] ADDR_IRQ_ENABLE = 32'hffff0704;
  localparam logic [31:0] ADDR_IRQ_IDENT = 32'hffff0708;
  localparam logic [31:0] ADDR_MUX_LOOP = 32'hffff0710;
  localparam logic [31:0] ADDR_LINE_STATUS = 32'hffff0714;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] RST_MUX_LOOP = 8'h00;
  localparam logic [7:0] RST_LINE_STATUS = 8'h60;
  // ==========================================================
  // field positions
  localparam int MUX_SEL_HI = 7;
  localparam int MUX_SEL_LO = 6;
  localparam int LOOP_BIT = 4;
  localparam int ST_TX_EMPTY = 6;
  localparam int ST_HOLD_EMPTY = 5;
  localparam int ST_BREAK = 4;
  localparam int ST_FRAME = 3;
  localparam int ST_PARITY = 2;
  localparam int ST_OVERRUN = 1;
  localparam int ST_READY = 0;
  localparam int EN_LINE = 2;
  localparam int EN_TX = 1;
  localparam int EN_RX = 0;
  // ==========================================================
  // receive input select codes
  localparam logic [1:0] SEL_LIN = 2'h0;
  localparam logic [1:0] SEL_PIN_FIVE = 2'h2;
  // interrupt identification codes, bit 0 low while pending
  localparam logic [2:0] IID_NONE = 3'h1;
  localparam logic [2:0] IID_LINE = 3'h6;
  localparam logic [2:0] IID_RX = 3'h4;
  localparam logic [2:0] IID_TX = 3'h2;
  // longest frame: start, 8 data, parity, 2 stop
  localparam logic [3:0] MAX_FRAME_BITS = 4'hc;
endpackage : uart_lsr_pkg

// [uart_pin_sync.sv]
// two-flop synchroniser for asynchronous pins
// assumes one clock; only the second stage is visible outside
`timescale 1ns/1ps
module uart_pin_sync #(
  parameter int W = 2
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // pins in, synchronised out
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] pin_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] stab_q;

  // =========================================================
  // pins idle high, so reset to ones to avoid a false break
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      meta_q <= '1;
      stab_q <= '1;
    end else begin
      meta_q <= pin_i;
      stab_q <= meta_q;
    end
  end

  assign pin_o = stab_q;
endmodule : uart_pin_sync

// [uart_status_irq_enable_mux.sv]
// uart receive input mux, loopback, line status flags and interrupt enables
// assumes the rest of the uart supplies the shift register, receiver and
// divisor latch access bit on the same clock; lin and pin five are async
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
// Overview of operation
// - select 00 feeds receiver from lin
// - select 10 feeds general pin five; others reserved
// - loopback bit forces transmit output high
// - transmitter empty when holding and shift empty
// - holding empty set when holding register empty
// - holding write clears both empty flags
// - break set when line low too long
// - framing error on bad stop bit
// - parity error on parity mismatch
// - overrun when unread character is overwritten
// - data ready set on receive, read clears
// - line interrupt on status bits 3..1
// - transmit interrupt when holding register becomes empty
// - receive interrupt when buffer becomes full
// - enable register hidden while latch access set
// - identification codes line, rx, tx priority
// - status read, tx write clear interrupts
module uart_status_irq_enable_mux
  import uart_lsr_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [31:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // line control from the rest of the uart
  input wire logic divisor_latch_access_bit_i,
  input wire logic bit_tick_i,
  // transmit side
  output logic [7:0] thr_data_o,
  output logic thr_valid_o,
  input wire logic shift_take_i,
  input wire logic shift_busy_i,
  input wire logic shift_out_i,
  output logic txd_o,
  // receive side
  input wire logic lin_rx_i,
  input wire logic general_pin_five_i,
  output logic serial_input_line_o,
  input wire logic rx_char_valid_i,
  input wire logic [7:0] rx_char_i,
  input wire logic rx_stop_ok_i,
  input wire logic rx_parity_ok_i,
  // interrupt request
  output logic irq_o
);
  import uart_lsr_pkg::*;

  // =========================================================
  // declarations
  logic [1:0] pins_s;
  logic mux_line;
  logic brk_pulse;
  logic [2:0] ier_q, ier_d;
  logic [1:0] sel_q, sel_d;
  logic loop_q, loop_d;
  logic [7:0] thr_q, thr_d;
  logic thr_full_q, thr_full_d;
  logic tx_empty_q, tx_empty_d;
  logic [7:0] rbr_q, rbr_d;
  logic [4:0] lsr_q, lsr_d; // break, frame, parity, overrun, ready
  logic tx_irq_q, tx_irq_d;
  logic hold_empty_prev_q;
  logic en_tx_prev_q;
  logic [7:0] rdata_q, rdata_d;
  logic wr_thr, rd_rbr, rd_lsr, rd_iid, wr_ier, wr_ctl;
  logic ls_pend, rx_pend;
  logic [2:0] iid;

  // =========================================================
  // pin synchronisers and break detection
  uart_pin_sync #(.W(2)) u_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .pin_i({general_pin_five_i, lin_rx_i}),
    .pin_o(pins_s)
  );

  uart_break_detect #(.MAX_BITS(MAX_FRAME_BITS)) u_brk (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .line_i(serial_input_line_o),
    .bit_tick_i(bit_tick_i),
    .break_o(brk_pulse)
  );

  // =========================================================
  // receive input mux; reserved codes hold the line idle
  always_comb begin
    if (sel_q == SEL_LIN) begin
      mux_line = pins_s[0];
    end else if (sel_q == SEL_PIN_FIVE) begin
      mux_line = pins_s[1];
    end else begin
      mux_line = 1'b1;
    end
  end

  // loopback: receiver hears our own shift output, line parked high
  assign serial_input_line_o = loop_q ? shift_out_i : mux_line;
  assign txd_o = loop_q | shift_out_i;

  // =========================================================
  // address decode; data and enable registers hide behind the latch bit
  always_comb begin
    wr_thr = 1'b0;
    rd_rbr = 1'b0;
    wr_ier = 1'b0;
    rd_iid = 1'b0;
    rd_lsr = 1'b0;
    wr_ctl = 1'b0;
    if (addr_i == ADDR_DATA) begin
      wr_thr = wr_i & ~divisor_latch_access_bit_i;
      rd_rbr = rd_i & ~divisor_latch_access_bit_i;
    end else if (addr_i == ADDR_IRQ_ENABLE) begin
      wr_ier = wr_i & ~divisor_latch_access_bit_i;
    end else if (addr_i == ADDR_IRQ_IDENT) begin
      rd_iid = rd_i;
    end else if (addr_i == ADDR_MUX_LOOP) begin
      wr_ctl = wr_i;
    end else if (addr_i == ADDR_LINE_STATUS) begin
      rd_lsr = rd_i; // writes here are dropped
    end
  end

  // =========================================================
  // control registers
  always_comb begin
    ier_d = ier_q;
    sel_d = sel_q;
    loop_d = loop_q;
    if (wr_ier) begin
      ier_d = wdata_i[2:0]; // bit 3 kept zero on read
    end
    if (wr_ctl) begin
      sel_d = wdata_i[MUX_SEL_HI:MUX_SEL_LO];
      loop_d = wdata_i[LOOP_BIT];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ier_q <= RST_IRQ_ENABLE[2:0];
      sel_q <= RST_MUX_LOOP[MUX_SEL_HI:MUX_SEL_LO];
      loop_q <= RST_MUX_LOOP[LOOP_BIT];
    end else begin
      ier_q <= ier_d;
      sel_q <= sel_d;
      loop_q <= loop_d;
    end
  end

  // =========================================================
  // transmit holding register and the two empty flags
  always_comb begin
    thr_d = thr_q;
    thr_full_d = thr_full_q;
    if (shift_take_i) begin
      thr_full_d = 1'b0;
    end
    if (wr_thr) begin
      thr_d = wdata_i;
      thr_full_d = 1'b1;
    end
    // empty only once nothing waits and nothing shifts
    tx_empty_d = ~thr_full_d & ~shift_busy_i & ~wr_thr;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      thr_q <= 8'h00;
      thr_full_q <= ~RST_LINE_STATUS[ST_HOLD_EMPTY];
      tx_empty_q <= RST_LINE_STATUS[ST_TX_EMPTY];
    end else begin
      thr_q <= thr_d;
      thr_full_q <= thr_full_d;
      tx_empty_q <= tx_empty_d;
    end
  end

  assign thr_data_o = thr_q;
  assign thr_valid_o = thr_full_q;

  // =========================================================
  // receive buffer and sticky flags; a set always beats a read clear
  always_comb begin
    rbr_d = rbr_q;
    lsr_d = lsr_q;
    if (rd_lsr) begin
      lsr_d[4:1] = 4'h0;
    end
    if (rd_rbr) begin
      lsr_d[ST_READY] = 1'b0;
    end
    if (brk_pulse) begin
      lsr_d[ST_BREAK] = 1'b1;
    end
    if (rx_char_valid_i) begin
      rbr_d = rx_char_i;
      lsr_d[ST_READY] = 1'b1;
      if (lsr_q[ST_READY] && !rd_rbr) begin
        lsr_d[ST_OVERRUN] = 1'b1;
      end
      if (!rx_stop_ok_i) begin
        lsr_d[ST_FRAME] = 1'b1;
      end
      if (!rx_parity_ok_i) begin
        lsr_d[ST_PARITY] = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rbr_q <= 8'h00;
      lsr_q <= RST_LINE_STATUS[4:0];
    end else begin
      rbr_q <= rbr_d;
      lsr_q <= lsr_d;
    end
  end

  // =========================================================
  // interrupt sources and identification
  assign ls_pend = ier_q[EN_LINE] & (|lsr_q[ST_FRAME:ST_OVERRUN]);
  assign rx_pend = ier_q[EN_RX] & lsr_q[ST_READY];

  always_comb begin
    if (ls_pend) begin
      iid = IID_LINE;
    end else if (rx_pend) begin
      iid = IID_RX;
    end else if (tx_irq_q) begin
      iid = IID_TX;
    end else begin
      iid = IID_NONE;
    end
  end

  // tx request arms on the empty edge or on enabling while empty,
  // and is dropped by a holding write or by reading it out of the id
  always_comb begin
    tx_irq_d = tx_irq_q;
    if (wr_thr || (rd_iid && iid == IID_TX)) begin
      tx_irq_d = 1'b0;
    end
    if (!thr_full_q && ier_q[EN_TX] && (!hold_empty_prev_q || !en_tx_prev_q)) begin
      tx_irq_d = 1'b1;
    end
    if (!ier_q[EN_TX]) begin
      tx_irq_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tx_irq_q <= 1'b0;
      hold_empty_prev_q <= RST_LINE_STATUS[ST_HOLD_EMPTY];
      en_tx_prev_q <= RST_IRQ_ENABLE[EN_TX];
    end else begin
      tx_irq_q <= tx_irq_d;
      hold_empty_prev_q <= ~thr_full_q;
      en_tx_prev_q <= ier_q[EN_TX];
    end
  end

  assign irq_o = ~iid[0];

  // =========================================================
  // read data, stands for the one cycle after the strobe
  always_comb begin
    rdata_d = 8'h00;
    if (rd_rbr) begin
      rdata_d = rbr_q;
    end else if (rd_i && addr_i == ADDR_IRQ_ENABLE && !divisor_latch_access_bit_i) begin
      rdata_d = {5'h00, ier_q};
    end else if (rd_iid) begin
      rdata_d = {5'h00, iid};
    end else if (rd_i && addr_i == ADDR_MUX_LOOP) begin
      rdata_d = {sel_q, 1'b0, loop_q, 4'h0};
    end else if (rd_lsr) begin
      rdata_d = {1'b0, tx_empty_q, ~thr_full_q, lsr_q};
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;

  // =========================================================
  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_loop_txd_high: assert property (loop_q |-> txd_o)
    else $error("loopback did not hold transmit high");
  a_mux_lin_path: assert property (!loop_q && sel_q == SEL_LIN |-> serial_input_line_o == pins_s[0])
    else $error("receiver not fed from lin");
  a_mux_pin_five: assert property (!loop_q && sel_q == SEL_PIN_FIVE |-> serial_input_line_o == pins_s[1])
    else $error("receiver not fed from pin five");
  a_loop_rx_route: assert property (loop_q |-> serial_input_line_o == shift_out_i)
    else $error("loopback not routed to receiver");
  a_thr_write_clears: assert property (wr_thr |=> thr_full_q && !tx_empty_q)
    else $error("holding write left empty flags set");
  a_empty_needs_hold: assert property (tx_empty_q |-> !thr_full_q)
    else $error("transmitter empty while holding full");
  a_hold_empty_take: assert property (shift_take_i && !wr_thr |=> !thr_full_q)
    else $error("holding empty not set after take");
  a_overrun_set: assert property (rx_char_valid_i && lsr_q[ST_READY] && !rd_rbr |=> lsr_q[ST_OVERRUN])
    else $error("overrun not flagged");
  a_frame_set: assert property (rx_char_valid_i && !rx_stop_ok_i |=> lsr_q[ST_FRAME])
    else $error("framing error missed");
  a_parity_set: assert property (rx_char_valid_i && !rx_parity_ok_i |=> lsr_q[ST_PARITY])
    else $error("parity error missed");
  a_ready_clear: assert property (rd_rbr && !rx_char_valid_i |=> !lsr_q[ST_READY])
    else $error("data ready not cleared by read");
  a_break_set: assert property (brk_pulse |=> lsr_q[ST_BREAK])
    else $error("break not flagged");
  a_status_clear: assert property (rd_lsr && !rx_char_valid_i && !brk_pulse |=> lsr_q[4:1] == 4'h0)
    else $error("status read left error flags");
  a_line_irq: assert property (ier_q[EN_LINE] && (|lsr_q[3:1]) |-> irq_o && iid == IID_LINE)
    else $error("line status interrupt missing");
  a_rx_irq: assert property (!ls_pend && rx_pend |-> irq_o && iid == IID_RX)
    else $error("receive interrupt wrong");
  a_iid_readback: assert property (rd_iid |=> rdata_o[2:0] == $past(iid))
    else $error("identification read mismatch");
  a_ier_hidden: assert property (wr_i && addr_i == ADDR_IRQ_ENABLE && divisor_latch_access_bit_i |=> $stable(ier_q))
    else $error("enable register written under latch access");
  a_tx_irq_arm: assert property (ier_q[EN_TX] && !en_tx_prev_q && !thr_full_q |=> tx_irq_q)
    else $error("transmit interrupt not armed");

  c_loop_char: cover property (loop_q && rx_char_valid_i);
  c_overrun: cover property (rx_char_valid_i && lsr_q[ST_READY]);
  c_tx_irq_cleared: cover property (tx_irq_q && rd_iid && iid == IID_TX);
  c_break_seen: cover property (brk_pulse);
endmodule : uart_status_irq_enable_mux

// [uart_status_irq_enable_mux_test.sv]
// self-checking bench for the status, input mux and enable block
// assumes the far-side model takes held bytes; pins and receiver driven here
`timescale 1ns/1ps
module uart_status_irq_enable_mux_test;
  import uart_lsr_pkg::*;
  logic core_clk_i, rst_i, wr_i, rd_i, latch_bit, tick, take, busy, sout, txd, lin, pin_five, sil;
  logic rxv, stok, pok, irq, thr_v, stall;
  logic [31:0] addr;
  logic [7:0] wdata, rdata, thr_d, rxc;
  int n_fail, num_checks;
  // =========================================================
  // instances
  uart_status_irq_enable_mux uart_status_irq_enable_mux_i (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata), .divisor_latch_access_bit_i(latch_bit), .bit_tick_i(tick),
    .thr_data_o(thr_d), .thr_valid_o(thr_v), .shift_take_i(take), .shift_busy_i(busy),
    .shift_out_i(sout), .txd_o(txd), .lin_rx_i(lin), .general_pin_five_i(pin_five),
    .serial_input_line_o(sil), .rx_char_valid_i(rxv), .rx_char_i(rxc),
    .rx_stop_ok_i(stok), .rx_parity_ok_i(pok), .irq_o(irq));
  uart_far_side uart_far_side_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .thr_valid_i(thr_v), .stall_i(stall), .shift_take_o(take), .shift_busy_o(busy),
    .shift_out_o(sout));
  // =========================================================
  // clock and helpers
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    wr_i <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [31:0] a, input logic [7:0] exp, input string what);
    @(posedge core_clk_i);
    rd_i <= 1'b1;
    addr <= a;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 chk(what, exp, rdata);
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : cyc
  // =========================================================
  // scenarios
  task automatic t_regs;
    rd(ADDR_IRQ_ENABLE, RST_IRQ_ENABLE, "enable reset");
    rd(ADDR_MUX_LOOP, RST_MUX_LOOP, "mux reset");
    rd(ADDR_LINE_STATUS, RST_LINE_STATUS, "status reset");
    rd(32'hffff0718, 8'h00, "unmapped");
    wr(ADDR_LINE_STATUS, 8'h9f);
    rd(ADDR_LINE_STATUS, 8'h60, "status after write");
    rd(ADDR_IRQ_IDENT, IID_NONE, "ident idle");
    latch_bit <= 1'b1;
    wr(ADDR_IRQ_ENABLE, 8'h07);
    rd(ADDR_IRQ_ENABLE, 8'h00, "enable hidden");
    wr(ADDR_DATA, 8'h55);
    rd(ADDR_LINE_STATUS, 8'h60, "holding hidden");
    latch_bit <= 1'b0;
    rd(ADDR_IRQ_ENABLE, 8'h00, "enable untouched");
  endtask : t_regs
  task automatic t_mux;
    wr(ADDR_MUX_LOOP, 8'h80);
    lin <= 1'b0;
    pin_five <= 1'b1;
    cyc(4);
    chk("pin five high", 1'b1, sil);
    pin_five <= 1'b0;
    lin <= 1'b1;
    cyc(4);
    chk("pin five low", 1'b0, sil);
    wr(ADDR_MUX_LOOP, 8'h00);
    cyc(4);
    chk("lin high", 1'b1, sil);
    lin <= 1'b0;
    cyc(4);
    chk("lin low", 1'b0, sil);
    wr(ADDR_MUX_LOOP, 8'h40);
    cyc(1);
    chk("reserved select idle", 1'b1, sil);
    lin <= 1'b1;
    wr(ADDR_MUX_LOOP, 8'h10);
    rd(ADDR_MUX_LOOP, 8'h10, "loop readback");
    wr(ADDR_DATA, 8'h3c);
    repeat (10) begin
      cyc(1);
      chk("txd in loop", 1'b1, txd);
      chk("loop route", sout, sil);
    end
    wr(ADDR_MUX_LOOP, 8'h00);
    cyc(8);
  endtask : t_mux
  task automatic t_tx;
    int k;
    stall <= 1'b1;
    wr(ADDR_DATA, 8'hc3);
    #1 chk("holding data", 8'hc3, thr_d);
    chk("holding valid", 1'b1, thr_v);
    rd(ADDR_LINE_STATUS, 8'h00, "status full");
    stall <= 1'b0;
    for (k = 0; k < 20 && thr_v !== 1'b0; k++) cyc(1);
    rd(ADDR_LINE_STATUS, 8'h20, "status shifting");
    for (k = 0; k < 20 && busy !== 1'b0; k++) cyc(1);
    cyc(2);
    rd(ADDR_LINE_STATUS, 8'h60, "status drained");
    wr(ADDR_IRQ_ENABLE, 8'h02);
    cyc(2);
    chk("tx irq", 1'b1, irq);
    rd(ADDR_IRQ_IDENT, IID_TX, "ident tx");
    cyc(1);
    chk("tx irq after ident", 1'b0, irq);
    wr(ADDR_IRQ_ENABLE, 8'h00);
  endtask : t_tx
  task automatic t_rx;
    wr(ADDR_IRQ_ENABLE, 8'h05);
    rxc <= 8'ha5;
    stok <= 1'b0;
    pok <= 1'b0;
    rxv <= 1'b1;
    @(posedge core_clk_i);
    rxv <= 1'b0;
    cyc(2);
    chk("line irq", 1'b1, irq);
    rd(ADDR_IRQ_IDENT, IID_LINE, "ident line");
    rd(ADDR_LINE_STATUS, 8'h6d, "status errors");
    rd(ADDR_IRQ_IDENT, IID_RX, "ident rx");
    rxc <= 8'h5a;
    stok <= 1'b1;
    pok <= 1'b1;
    rxv <= 1'b1;
    @(posedge core_clk_i);
    rxv <= 1'b0;
    rd(ADDR_LINE_STATUS, 8'h63, "status overrun");
    rd(ADDR_DATA, 8'h5a, "rx byte");
    rd(ADDR_LINE_STATUS, 8'h60, "status read out");
    chk("irq quiet", 1'b0, irq);
    wr(ADDR_IRQ_ENABLE, 8'h00);
  endtask : t_rx
  task automatic t_break;
    lin <= 1'b0;
    repeat (12) begin
      cyc(2);
      tick <= 1'b1;
      @(posedge core_clk_i);
      tick <= 1'b0;
    end
    cyc(3);
    rd(ADDR_LINE_STATUS, 8'h60, "no break yet");
    tick <= 1'b1;
    @(posedge core_clk_i);
    tick <= 1'b0;
    cyc(3);
    rd(ADDR_LINE_STATUS, 8'h70, "break");
    rd(ADDR_LINE_STATUS, 8'h60, "break cleared");
    lin <= 1'b1;
  endtask : t_break
  // =========================================================
  // run control
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (5000) @(posedge core_clk_i);
    n_fail++;
    complete_run();
  end
  initial begin
    n_fail = 0;
    num_checks = 0;
    {rst_i, wr_i, rd_i, latch_bit, tick, rxv, stall} = 7'h40;
    {lin, pin_five, stok, pok} = 4'hf;
    addr = 32'h0;
    wdata = 8'h00;
    rxc = 8'h00;
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_mux();
    t_tx();
    t_rx();
    t_break();
    complete_run();
  end
endmodule : uart_status_irq_enable_mux_test
